// ### hdl/alr_pkg.sv
// shared constants for the auxiliary limit and identity register bank
package alr_pkg;
    // ****************************************
    // bus shape
    // ****************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // ****************************************
    // register indices, byte address is four times the index
    // ****************************************
    localparam logic [7:0] IDX_AUX3_HIGH     = 8'hA0;
    localparam logic [7:0] IDX_AUX4_LOW      = 8'hA2;
    localparam logic [7:0] IDX_AUX4_HIGH     = 8'hA4;
    localparam logic [7:0] IDX_AUX5_LOW      = 8'hA6;
    localparam logic [7:0] IDX_AUX5_HIGH     = 8'hA8;
    localparam logic [7:0] IDX_AUX6_LOW      = 8'hAA;
    localparam logic [7:0] IDX_AUX6_HIGH     = 8'hAC;
    localparam logic [7:0] IDX_AUX7_LOW      = 8'hAE;
    localparam logic [7:0] IDX_AUX7_HIGH     = 8'hB0;
    localparam logic [7:0] IDX_LOT_FIRST     = 8'hBE;
    localparam logic [7:0] IDX_LOT_LAST      = 8'hC5;
    localparam logic [7:0] IDX_SERIAL_HI     = 8'hC6;
    localparam logic [7:0] IDX_SERIAL_LO     = 8'hC7;
    localparam logic [7:0] IDX_SCRATCH_FIRST = 8'hC8;
    localparam logic [7:0] IDX_SCRATCH_LAST  = 8'hCF;
    // ****************************************
    // limit field layout and reset values
    // ****************************************
    localparam int         LIMIT_MSB     = 15;
    localparam int         LIMIT_LSB     = 2;
    localparam int         LIMIT_W       = LIMIT_MSB - LIMIT_LSB + 1;
    localparam logic [1:0] LIMIT_PAD     = 2'h0;
    localparam logic [13:0] HIGH_RESET   = 14'h3FFF;
    localparam logic [13:0] LOW_RESET    = 14'h0000;
    localparam logic [7:0]  SCRATCH_RESET = 8'h00;
    localparam int         FIRST_HIGH_CH = 3;
    localparam int         FIRST_LOW_CH  = 4;
    localparam int         LAST_CH       = 7;

    // index of the high limit of a channel
    function automatic logic [7:0] high_idx(input int ch);
        return (ch == FIRST_HIGH_CH) ? IDX_AUX3_HIGH : 8'((ch - FIRST_LOW_CH) * 4 + int'(IDX_AUX4_HIGH));
    endfunction : high_idx

    // index of the low limit of a channel
    function automatic logic [7:0] low_idx(input int ch);
        return 8'((ch - FIRST_LOW_CH) * 4 + int'(IDX_AUX4_LOW));
    endfunction : low_idx

    // full comparison value from a limit field
    function automatic logic [15:0] limit_value(input logic [13:0] field);
        return {field, LIMIT_PAD};
    endfunction : limit_value
endpackage : alr_pkg

// ### hdl/alr_byte_store.sv
// byte wide user storage with one write port and one read port
`timescale 1ns/1ps
module alr_byte_store import alr_pkg::*; #(
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // write port
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_sel,
    input  wire logic [7:0]               wr_byte,
    // read port
    input  wire logic [$clog2(DEPTH)-1:0] rd_sel,
    output      logic [7:0]               rd_byte
);
    if (DEPTH < 2 || DEPTH > 8) begin : g_bad_depth
        $error("alr_byte_store: DEPTH must be 2 to 8");
    end

    logic [7:0] mem_q [DEPTH];
    logic [7:0] mem_d [DEPTH];

    always_comb begin
        mem_d = mem_q;
        if (wr_en) begin
            mem_d[wr_sel] = wr_byte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= SCRATCH_RESET;
            end
        end else begin
            mem_q <= mem_d;
        end
    end

    assign rd_byte = mem_q[rd_sel];
endmodule : alr_byte_store

// ### hdl/alr_limit_cmp.sv
// compares one auxiliary sample against its low and high limits
`timescale 1ns/1ps
module alr_limit_cmp import alr_pkg::*; (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // sample in
    input  wire logic        smp_valid,
    input  wire logic [2:0]  smp_chan,
    input  wire logic [15:0] smp_code,
    // limits of the sampled channel
    input  wire logic        low_en,
    input  wire logic        high_en,
    input  wire logic [13:0] low_field,
    input  wire logic [13:0] high_field,
    // fault out
    output      logic        fault_valid,
    output      logic [2:0]  fault_chan,
    output      logic        fault_under,
    output      logic        fault_over
);
    logic       valid_q, valid_d;
    logic [2:0] chan_q,  chan_d;
    logic       under_q, under_d;
    logic       over_q,  over_d;
    logic       under_now;
    logic       over_now;

    always_comb begin
        under_now = low_en && (smp_code < limit_value(low_field));
        over_now  = high_en && (smp_code > limit_value(high_field));
        valid_d   = smp_valid && (under_now || over_now);
        chan_d    = smp_valid ? smp_chan : chan_q;
        under_d   = smp_valid ? under_now : under_q;
        over_d    = smp_valid ? over_now : over_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_q <= 1'b0;
            chan_q  <= 3'h0;
            under_q <= 1'b0;
            over_q  <= 1'b0;
        end else begin
            valid_q <= valid_d;
            chan_q  <= chan_d;
            under_q <= under_d;
            over_q  <= over_d;
        end
    end

    assign fault_valid = valid_q;
    assign fault_chan  = chan_q;
    assign fault_under = under_q;
    assign fault_over  = over_q;
endmodule : alr_limit_cmp

// ### hdl/alr_aux_limit_regs.sv
// auxiliary limit, identity and scratch registers behind an apb slave
//
// Behaviour
// - each high limit register keeps in bits 15:2 the high limit for that auxiliary channel (3 to 7).
// - each low limit register of channels 4 to 7 keeps in bits 15:2 the low limit for that channel.
// - limit fields and samples are unsigned codes over 0 V to 5 V, so comparisons are unsigned.
// - the two lowest bits of a limit register are never stored and always read back as zero.
// - a 64-bit lot number reads over eight byte registers and cannot be written.
// - a 16-bit serial number reads over two byte registers.
// - eight scratch bytes read back exactly what was written and steer nothing.
// - the comparison value is the 14-bit field with two zero bits appended below it.
`timescale 1ns/1ps
module alr_aux_limit_regs import alr_pkg::*; #(
    parameter logic [63:0] LOT_ID    = 64'h0011223344556677, // arbitrary value
    parameter logic [15:0] SERIAL_ID = 16'h1234              // arbitrary value
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output      logic [DATA_W-1:0] prdata,
    output      logic              pready,
    output      logic              pslverr,
    // auxiliary samples
    input  wire logic              aux_sample_valid,
    input  wire logic [2:0]        aux_sample_chan,
    input  wire logic [15:0]       aux_sample_code,
    // faults
    output      logic              fault_valid,
    output      logic [2:0]        fault_chan,
    output      logic              fault_under,
    output      logic              fault_over
);
    // ****************************************
    // state
    // ****************************************
    logic [13:0]       hi_q [FIRST_HIGH_CH:LAST_CH];
    logic [13:0]       hi_d [FIRST_HIGH_CH:LAST_CH];
    logic [13:0]       lo_q [FIRST_LOW_CH:LAST_CH];
    logic [13:0]       lo_d [FIRST_LOW_CH:LAST_CH];
    logic [DATA_W-1:0] prdata_q, prdata_d;
    logic              err_q, err_d;

    // ****************************************
    // address decode
    // ****************************************
    logic [7:0]  idx;
    logic        aligned;
    logic        setup;
    logic        wr_go;
    logic        hit;
    logic        hit_limit;
    logic        ro;
    logic        sc_hit;
    logic [7:0]  rd;
    logic [7:0]  sc_rd;
    logic [2:0]  sc_sel;
    logic [5:0]  lot_shift;
    logic [15:0] wr_merged;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [1:0] strb);
        return {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    assign idx     = paddr[9:2];
    assign aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
    assign setup   = psel && !penable;
    assign wr_go   = psel && penable && pready && pwrite && !err_q;
    assign sc_hit  = aligned && (idx >= IDX_SCRATCH_FIRST) && (idx <= IDX_SCRATCH_LAST);
    assign sc_sel  = 3'(idx - IDX_SCRATCH_FIRST);
    assign lot_shift = 6'(8 * int'(IDX_LOT_LAST - idx));

    always_comb begin
        hit       = 1'b0;
        hit_limit = 1'b0;
        ro        = 1'b0;
        rd        = 8'h00;
        prdata_d  = '0;
        for (int c = FIRST_HIGH_CH; c <= LAST_CH; c++) begin
            if (aligned && idx == high_idx(c)) begin
                hit_limit = 1'b1;
                prdata_d  = 32'(limit_value(hi_q[c]));
            end
        end
        for (int c = FIRST_LOW_CH; c <= LAST_CH; c++) begin
            if (aligned && idx == low_idx(c)) begin
                hit_limit = 1'b1;
                prdata_d  = 32'(limit_value(lo_q[c]));
            end
        end
        if (aligned && idx >= IDX_LOT_FIRST && idx <= IDX_LOT_LAST) begin
            ro = 1'b1;
            rd = 8'(LOT_ID >> lot_shift);
        end
        if (aligned && idx == IDX_SERIAL_HI) begin
            ro = 1'b1;
            rd = SERIAL_ID[15:8];
        end
        if (aligned && idx == IDX_SERIAL_LO) begin
            ro = 1'b1;
            rd = SERIAL_ID[7:0];
        end
        if (sc_hit) begin
            rd = sc_rd;
        end
        if (ro || sc_hit) begin
            prdata_d = 32'(rd);
        end
        hit = hit_limit || ro || sc_hit;
        if (!setup) begin
            prdata_d = prdata_q;
        end else if (pwrite) begin
            prdata_d = '0;
        end
        err_d = setup ? (!hit || (pwrite && ro)) : err_q;
    end

    // ****************************************
    // limit write path
    // ****************************************
    always_comb begin
        hi_d = hi_q;
        lo_d = lo_q;
        wr_merged = 16'h0000;
        for (int c = FIRST_HIGH_CH; c <= LAST_CH; c++) begin
            if (wr_go && aligned && idx == high_idx(c)) begin
                wr_merged = merge16(limit_value(hi_q[c]), pwdata[15:0], pstrb[1:0]);
                hi_d[c]   = wr_merged[LIMIT_MSB:LIMIT_LSB];
            end
        end
        for (int c = FIRST_LOW_CH; c <= LAST_CH; c++) begin
            if (wr_go && aligned && idx == low_idx(c)) begin
                wr_merged = merge16(limit_value(lo_q[c]), pwdata[15:0], pstrb[1:0]);
                lo_d[c]   = wr_merged[LIMIT_MSB:LIMIT_LSB];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = FIRST_HIGH_CH; c <= LAST_CH; c++) begin
                hi_q[c] <= HIGH_RESET;
            end
            for (int c = FIRST_LOW_CH; c <= LAST_CH; c++) begin
                lo_q[c] <= LOW_RESET;
            end
            prdata_q <= '0;
            err_q    <= 1'b0;
        end else begin
            hi_q     <= hi_d;
            lo_q     <= lo_d;
            prdata_q <= prdata_d;
            err_q    <= err_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && err_q;

    // ****************************************
    // limit fields by channel
    // ****************************************
    logic [13:0]  aux3_high_limit_field;
    logic [13:0]  aux4_low_limit_field;
    logic [13:0]  aux4_high_limit_field;
    logic [13:0]  aux5_low_limit_field;
    logic [13:0]  aux5_high_limit_field;
    logic [13:0]  aux6_low_limit_field;
    logic [13:0]  aux6_high_limit_field;
    logic [13:0]  aux7_low_limit_field;
    logic [13:0]  aux7_high_limit_field;
    logic [125:0] limit_fields;

    assign aux3_high_limit_field = hi_q[3];
    assign aux4_low_limit_field  = lo_q[4];
    assign aux4_high_limit_field = hi_q[4];
    assign aux5_low_limit_field  = lo_q[5];
    assign aux5_high_limit_field = hi_q[5];
    assign aux6_low_limit_field  = lo_q[6];
    assign aux6_high_limit_field = hi_q[6];
    assign aux7_low_limit_field  = lo_q[7];
    assign aux7_high_limit_field = hi_q[7];
    assign limit_fields = {aux3_high_limit_field, aux4_low_limit_field, aux4_high_limit_field,
                           aux5_low_limit_field, aux5_high_limit_field, aux6_low_limit_field,
                           aux6_high_limit_field, aux7_low_limit_field, aux7_high_limit_field};

    // ****************************************
    // scratch bytes
    // ****************************************
    alr_byte_store #(
        .DEPTH (8)
    ) u_scratch (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_go && sc_hit && pstrb[0]),
        .wr_sel  (sc_sel),
        .wr_byte (pwdata[7:0]),
        .rd_sel  (sc_sel),
        .rd_byte (sc_rd)
    );

    // ****************************************
    // limit comparison
    // ****************************************
    logic        low_en;
    logic        high_en;
    logic [13:0] low_sel;
    logic [13:0] high_sel;

    always_comb begin
        low_en   = 1'b0;
        high_en  = 1'b0;
        low_sel  = LOW_RESET;
        high_sel = HIGH_RESET;
        for (int c = FIRST_HIGH_CH; c <= LAST_CH; c++) begin
            if (int'(aux_sample_chan) == c) begin
                high_en  = 1'b1;
                high_sel = hi_q[c];
            end
        end
        for (int c = FIRST_LOW_CH; c <= LAST_CH; c++) begin
            if (int'(aux_sample_chan) == c) begin
                low_en  = 1'b1;
                low_sel = lo_q[c];
            end
        end
    end

    alr_limit_cmp u_cmp (
        .pclk        (pclk),
        .presetn     (presetn),
        .smp_valid   (aux_sample_valid),
        .smp_chan    (aux_sample_chan),
        .smp_code    (aux_sample_code),
        .low_en      (low_en),
        .high_en     (high_en),
        .low_field   (low_sel),
        .high_field  (high_sel),
        .fault_valid (fault_valid),
        .fault_chan  (fault_chan),
        .fault_under (fault_under),
        .fault_over  (fault_over)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_rsvd_zero: assert property (setup && !pwrite && hit_limit |=> prdata[1:0] == 2'h0)
        else $error("limit read shows nonzero low bits");
    chk_high_store: assert property (wr_go && aligned && idx == IDX_AUX3_HIGH && pstrb[1:0] == 2'h3
        |=> hi_q[3] == $past(pwdata[15:2]))
        else $error("high limit not stored");
    chk_low_store: assert property (wr_go && aligned && idx == IDX_AUX4_LOW && pstrb[1:0] == 2'h3
        |=> lo_q[4] == $past(pwdata[15:2]))
        else $error("low limit not stored");
    chk_lot_value: assert property (setup && !pwrite && aligned && idx == IDX_LOT_FIRST
        |=> prdata == 32'(LOT_ID[63:56]))
        else $error("lot first byte wrong");
    chk_lot_locked: assert property (setup && pwrite && aligned && idx == IDX_LOT_LAST
        ##1 penable |-> pslverr)
        else $error("lot write not refused");
    chk_serial_value: assert property (setup && !pwrite && aligned && idx == IDX_SERIAL_LO
        |=> prdata == 32'(SERIAL_ID[7:0]))
        else $error("serial low byte wrong");
    chk_scratch_echo: assert property (wr_go && sc_hit && pstrb[0] ##1 setup && !pwrite && sc_hit
        && idx == $past(idx) |=> prdata[7:0] == $past(pwdata[7:0], 2))
        else $error("scratch byte not echoed");
    chk_over_flag: assert property (aux_sample_valid && aux_sample_chan == 3'h3
        && aux_sample_code > {hi_q[3], 2'h0} |=> fault_valid && fault_over && fault_chan == 3'h3)
        else $error("overvoltage not flagged");
    chk_under_flag: assert property (aux_sample_valid && aux_sample_chan == 3'h4
        && aux_sample_code < {lo_q[4], 2'h0} |=> fault_valid && fault_under)
        else $error("undervoltage not flagged");
    chk_zero_in_range: assert property (aux_sample_valid && aux_sample_code == 16'h0000
        |=> !fault_over)
        else $error("zero code flagged high");

    // ****************************************
    // identity and scratch checks
    // ****************************************
    chk_lot_last: assert property (setup && !pwrite
        && aligned && idx == IDX_LOT_LAST
        |=> prdata == 32'(LOT_ID[7:0]))
        else $error("lot last byte wrong");

    chk_serial_high: assert property (setup && !pwrite
        && aligned && idx == IDX_SERIAL_HI
        |=> prdata == 32'(SERIAL_ID[15:8]))
        else $error("serial high byte wrong");

    chk_byte_upper: assert property (setup && !pwrite
        && sc_hit
        |=> prdata[31:8] == 24'h000000)
        else $error("scratch read upper bits set");

    chk_scratch_quiet: assert property (wr_go
        && sc_hit
        |=> $stable(limit_fields))
        else $error("scratch write moved a limit");

    // ****************************************
    // fault checks
    // ****************************************
    chk_chan_low_quiet: assert property (aux_sample_valid
        && aux_sample_chan < 3'h3
        |=> !fault_valid)
        else $error("channel below three flagged");

    chk_aux3_no_under: assert property (aux_sample_valid
        && aux_sample_chan == 3'h3
        |=> !fault_under)
        else $error("aux3 flagged low");

    chk_over_seven: assert property (aux_sample_valid && aux_sample_chan == 3'h7
        && aux_sample_code > limit_value(aux7_high_limit_field)
        |=> fault_valid && fault_over && fault_chan == 3'h7)
        else $error("aux7 high not flagged");

    chk_under_seven: assert property (aux_sample_valid && aux_sample_chan == 3'h7
        && aux_sample_code < limit_value(aux7_low_limit_field)
        |=> fault_valid && fault_under && fault_chan == 3'h7)
        else $error("aux7 low not flagged");

    chk_equal_high: assert property (aux_sample_valid && aux_sample_chan == 3'h5
        && aux_sample_code == limit_value(aux5_high_limit_field)
        |=> !fault_over)
        else $error("equal code flagged high");

    cov_lot_read:   cover property (setup && !pwrite && ro);
    cov_scratch_wr: cover property (wr_go && sc_hit);
    cov_over:       cover property (fault_valid && fault_over);
    cov_under:      cover property (fault_valid && fault_under);
    cov_refused:    cover property (psel && penable && pslverr);
endmodule : alr_aux_limit_regs

// ### verification/alr_host_model.sv
// apb host model that reads and writes the register bank
`timescale 1ns/1ps
module alr_host_model import alr_pkg::*; (
    // clock
    input  wire logic              pclk,
    // apb requester side
    output      logic              psel,
    output      logic              penable,
    output      logic              pwrite,
    output      logic [ADDR_W-1:0] paddr,
    output      logic [DATA_W-1:0] pwdata,
    output      logic [3:0]        pstrb,
    // apb answer
    input  wire logic [DATA_W-1:0] prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
        pstrb   = 4'h0;
    end

    // one transfer, entered right after a rising edge; gap 0 keeps psel for a back-to-back setup
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input logic [3:0] s, input int gap, output logic [DATA_W-1:0] rd,
                        output logic err, output logic ok);
        int n;
        ok = 1'b0;
        rd = '0;
        err = 1'b0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        pstrb  <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 64 && !ok; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                ok  = 1'b1;
                rd  = prdata;
                err = pslverr;
            end
        end
        penable <= 1'b0;
        if (gap > 0) begin
            psel   <= 1'b0;
            paddr  <= ~a;
            pwdata <= ~d;
            repeat (gap) @(posedge pclk);
        end
    endtask : xfer
endmodule : alr_host_model

// ### verification/test_alr_aux_limit_regs.sv
// self-checking bench for the auxiliary limit and identity register bank
`timescale 1ns/1ps
module test_alr_aux_limit_regs import alr_pkg::*; ;
    localparam logic [63:0] LOT_VAL = 64'hA5C3_0F1E_7B29_D486; // arbitrary value
    localparam logic [15:0] SER_VAL = 16'h5AE7;                // arbitrary value
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0]        pstrb;
    logic              aux_sample_valid = 1'b0;
    logic [2:0]        aux_sample_chan = 3'h0;
    logic [15:0]       aux_sample_code = 16'h0000;
    logic              fault_valid, fault_under, fault_over, err, ok;
    logic [2:0]        fault_chan;
    int unsigned       shadow[256];
    bit                mapped[256], ro[256], is_lim[256];
    int                fail_count = 0;
    int                compares = 0;
    int                cm;
    bit                exp_fv, exp_u, exp_o;
    logic [2:0]        exp_chan;

    always #4 pclk = ~pclk;

    alr_aux_limit_regs #(.LOT_ID(LOT_VAL), .SERIAL_ID(SER_VAL)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .aux_sample_valid(aux_sample_valid), .aux_sample_chan(aux_sample_chan),
        .aux_sample_code(aux_sample_code), .fault_valid(fault_valid), .fault_chan(fault_chan),
        .fault_under(fault_under), .fault_over(fault_over));
    alr_host_model host (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ****************************************
    // reference model
    // ****************************************
    function automatic int hi_ix(input int c);
        return (c == 3) ? 8'hA0 : 8'hA4 + (c - 4) * 4;
    endfunction : hi_ix

    function automatic int lo_ix(input int c);
        return 8'hA2 + (c - 4) * 4;
    endfunction : lo_ix

    task automatic init_model();
        for (int i = 0; i < 256; i++) begin
            shadow[i] = 0;
            mapped[i] = 1'b0;
            ro[i] = 1'b0;
            is_lim[i] = 1'b0;
        end
        for (int c = 3; c <= 7; c++) begin
            mapped[hi_ix(c)] = 1'b1;
            is_lim[hi_ix(c)] = 1'b1;
            shadow[hi_ix(c)] = 32'h0000_FFFC;
            if (c > 3) begin
                mapped[lo_ix(c)] = 1'b1;
                is_lim[lo_ix(c)] = 1'b1;
            end
        end
        for (int i = 0; i < 8; i++) begin
            mapped[8'hBE + i] = 1'b1;
            ro[8'hBE + i] = 1'b1;
            shadow[8'hBE + i] = LOT_VAL[63 - 8 * i -: 8];
            mapped[8'hC8 + i] = 1'b1;
        end
        for (int i = 0; i < 2; i++) begin
            mapped[8'hC6 + i] = 1'b1;
            ro[8'hC6 + i] = 1'b1;
            shadow[8'hC6 + i] = SER_VAL[15 - 8 * i -: 8];
        end
    endtask : init_model

    // expected fault from the sample taken at this edge
    always @(posedge pclk) begin
        cm = int'(aux_sample_chan);
        exp_u = aux_sample_valid === 1'b1 && cm >= 4 && aux_sample_code < shadow[lo_ix(cm)];
        exp_o = aux_sample_valid === 1'b1 && cm >= 3 && aux_sample_code > shadow[hi_ix(cm)];
        exp_fv = exp_u || exp_o;
        exp_chan = aux_sample_chan;
    end

    always @(negedge pclk) begin
        if (presetn === 1'b1) begin
            check(fault_valid === exp_fv, "fault pulse");
            if (exp_fv) check({fault_chan, fault_under, fault_over} === {exp_chan, exp_u, exp_o}, "fault detail");
        end
    end

    // ****************************************
    // checks and stimulus
    // ****************************************
    task automatic check(input logic good, input string what);
        compares++;
        if (good !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : check

    task automatic test_done();
        $display("checks run: %0d, mismatches: %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    task automatic do_reset();
        presetn <= 1'b0;
        init_model();
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : do_reset

    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [3:0] s, input int gap);
        int          ix;
        bit          legal;
        int unsigned m;
        ix = int'(a[9:2]);
        legal = a[1:0] == 2'b00 && a[11:10] == 2'b00 && mapped[ix] && !(wr && ro[ix]);
        host.xfer(wr, a, d, s, gap, rd, err, ok);
        if (ok !== 1'b1) begin
            check(1'b0, "no answer");
            test_done();
        end
        check(err === !legal, "error response");
        if (!wr) begin
            check(rd === (legal ? shadow[ix] : 32'h0000_0000), "read data");
        end else if (legal) begin
            m = is_lim[ix] ? {s[1] ? 8'hFF : 8'h00, s[0] ? 8'hFF : 8'h00} : (s[0] ? 32'hFF : 32'h0);
            shadow[ix] = ((shadow[ix] & ~m) | (d & m)) & (is_lim[ix] ? 32'hFFFC : 32'hFF);
        end
    endtask : bus

    task automatic read_all();
        for (int ix = 8'hA0; ix <= 8'hCF; ix++) bus(1'b0, 12'(ix * 4), 32'h0, 4'h0, ix % 3 || ix == 8'hCF);
    endtask : read_all

    task automatic samples(input int n);
        int unsigned hi, lo, v;
        int          c;
        for (int i = 0; i < n; i++) begin
            c = $urandom_range(7, 0);
            hi = shadow[hi_ix(c < 3 ? 3 : c)];
            lo = (c < 4) ? 0 : shadow[lo_ix(c)];
            case ($urandom_range(4, 0))
                0: v = hi;
                1: v = hi + 1;
                2: v = lo;
                3: v = lo - 1;
                default: v = $urandom;
            endcase
            aux_sample_valid <= 1'b1;
            aux_sample_chan  <= 3'(c);
            aux_sample_code  <= v[15:0];
            @(posedge pclk);
        end
        aux_sample_valid <= 1'b0;
        @(posedge pclk);
    endtask : samples

    initial begin
        void'($urandom(3215));
        do_reset();
        read_all();
        samples(40);
        for (int r = 0; r < 4; r++) begin
            for (int c = 3; c <= 7; c++) begin
                bus(1'b1, 12'(hi_ix(c) * 4), $urandom & 32'hFFFF_FFFC, 4'hF, 0);
                if (c > 3) bus(1'b1, 12'(lo_ix(c) * 4), $urandom & 32'hFFFF_FFFC, 4'hF, c == 7);
            end
            read_all();
            samples(150);
        end
        bus(1'b1, 12'h2A8, 32'hFFFF_9A37, 4'h2, 1);
        bus(1'b0, 12'h2A8, 32'h0, 4'h0, 1);
        for (int ix = 8'hBE; ix <= 8'hCF; ix++) begin
            bus(1'b1, 12'(ix * 4), $urandom, 4'(1 + $urandom_range(14, 0)), 0);
            bus(1'b0, 12'(ix * 4), 32'h0, 4'h0, 1);
        end
        read_all();
        samples(40);
        bus(1'b0, 12'h281, 32'h0, 4'h0, 1);
        bus(1'b1, 12'h680, 32'h0000_1234, 4'hF, 1);
        bus(1'b1, 12'h284, 32'h0000_1234, 4'hF, 1);
        bus(1'b0, 12'h2C4, 32'h0, 4'h0, 1);
        do_reset();
        read_all();
        test_done();
    end
endmodule : test_alr_aux_limit_regs
